//--- pkg/bdsr_pkg.sv
/*
  Constants, field positions, commands and carrier types for the background
  debug status, breakpoint and forced-reset block.
  Assumes a serial link decoder upstream that delivers whole debug commands.
*/
`default_nettype none
package bdsr_pkg;
  // Status/control field positions
  localparam int STAT_ENABLE = 7;
  localparam int STAT_ACTIVE = 6;
  localparam int STAT_BKPT_EN = 5;
  localparam int STAT_FORCE_TAG = 4;
  localparam int STAT_CLKSW = 3;
  localparam int STAT_LOW_POWER = 2;
  localparam int STAT_ACCESS_FAIL = 1;
  localparam int STAT_DATA_VALID_FAIL = 0;
  localparam int FORCE_RESET_BIT = 0;
  // Reset values and masks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hb8;
  localparam logic [15:0] BKPT_RESET = 16'h0000;
  localparam logic [7:0] FORCE_RESET_READ = 8'h00;
  localparam logic [15:0] FORCE_RESET_ADDR = 16'hfff0;
  localparam logic [15:0] RSP_IDLE = 16'h0000;

  typedef enum logic [2:0] {
    op_background,
    op_read_status,
    op_write_control,
    op_breakpoint_read_command,
    op_breakpoint_write_command,
    op_read_byte,
    op_write_byte
  } bdsr_op_type;

  typedef struct packed {
    logic valid;
    bdsr_op_type op;
    logic [15:0] addr;
    logic [15:0] data;
  } bdsr_cmd_type;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [15:0] data;
  } bdsr_rsp_type;

  typedef struct packed {
    logic low_power;
    logic debug_active;
    logic wait_conflict;
  } bdsr_cpu_type;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } bdsr_user_wr_type;
endpackage : bdsr_pkg
`default_nettype wire

//--- design/bdsr_core.sv
/*
  Debug status/control bits, breakpoint match register and forced reset.
  Assumes decoded serial commands on cmd and CPU mode levels on cpu.
*/
`timescale 1ns/1ps
`default_nettype none
module bdsr_core #(
  parameter logic [15:0] FORCE_ADDR = bdsr_pkg::FORCE_RESET_ADDR
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial command side
  input wire bdsr_pkg::bdsr_cmd_type cmd,
  output bdsr_pkg::bdsr_rsp_type rsp,
  // CPU side
  input wire bdsr_pkg::bdsr_cpu_type cpu,
  input wire bdsr_pkg::bdsr_user_wr_type user_wr,
  output logic background_req,
  output logic system_reset_req,
  // Breakpoint configuration
  output logic breakpoint_enable,
  output logic force_tag_select,
  output logic [15:0] breakpoint_match_address
);
  import bdsr_pkg::*;

  typedef enum {st_idle, st_wake_req, st_wake_active} bdsr_wake_type;

  bdsr_wake_type wake_state;
  bdsr_wake_type next_wake_state;
  logic enable_debug;
  logic clock_select;
  logic low_power_status;
  logic low_power_access_failure;
  logic data_valid_failure;
  logic cmd_refused;
  logic cmd_ok;
  logic is_mem_op;
  logic force_hit;

  function automatic logic mem_op(input bdsr_op_type op);
    mem_op = (op == op_read_byte) || (op == op_write_byte);
  endfunction : mem_op

  ////////////////////////////////////////////////////////////////////////
  // Command qualification
  assign cmd_refused = cmd.valid && cpu.low_power && (cmd.op != op_background);
  assign cmd_ok = cmd.valid && !cmd_refused;
  assign is_mem_op = mem_op(cmd.op);
  assign force_hit = is_mem_op && (cmd.addr == FORCE_ADDR);
  assign data_valid_failure = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Wake tracking
  always_comb begin
    next_wake_state = wake_state;
    case (wake_state)
      st_idle: begin
        if (cmd.valid && cmd.op == op_background && cpu.low_power && enable_debug) begin
          next_wake_state = st_wake_req;
        end
      end
      st_wake_req: begin
        if (cpu.debug_active) begin
          next_wake_state = st_wake_active;
        end
      end
      st_wake_active: begin
        if (!cpu.debug_active) begin
          next_wake_state = st_idle;
        end
      end
      default: next_wake_state = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_state <= st_idle;
    end else begin
      wake_state <= next_wake_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_power_status <= 1'b0;
    end else begin
      low_power_status <= cpu.low_power || (next_wake_state != st_idle);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      background_req <= 1'b0;
    end else begin
      background_req <= cmd.valid && cmd.op == op_background && enable_debug;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access failure flag, set wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_power_access_failure <= 1'b0;
    end else if ((cmd_refused && is_mem_op) || cpu.wait_conflict) begin
      low_power_access_failure <= 1'b1;
    end else if (cmd_ok && is_mem_op) begin
      low_power_access_failure <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control bits, status bits not writable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enable_debug <= CTRL_RESET[STAT_ENABLE];
      breakpoint_enable <= CTRL_RESET[STAT_BKPT_EN];
      force_tag_select <= CTRL_RESET[STAT_FORCE_TAG];
      clock_select <= CTRL_RESET[STAT_CLKSW];
    end else if (cmd_ok && cmd.op == op_write_control) begin
      if (!cpu.debug_active) begin
        enable_debug <= cmd.data[STAT_ENABLE] & CTRL_WRITE_MASK[STAT_ENABLE];
      end
      breakpoint_enable <= cmd.data[STAT_BKPT_EN];
      force_tag_select <= cmd.data[STAT_FORCE_TAG];
      clock_select <= cmd.data[STAT_CLKSW];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Breakpoint match register, commands only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      breakpoint_match_address <= BKPT_RESET;
    end else if (cmd_ok && cmd.op == op_breakpoint_write_command) begin
      breakpoint_match_address <= cmd.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Forced reset, user writes never reach it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= cmd_ok && cmd.op == op_write_byte && force_hit
        && cmd.data[FORCE_RESET_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cmd.valid;
      rsp.refused <= cmd_refused;
      rsp.data <= RSP_IDLE;
      if (cmd_ok) begin
        case (cmd.op)
          op_read_status: begin
            rsp.data <= {8'h00, enable_debug, cpu.debug_active, breakpoint_enable,
              force_tag_select, clock_select, low_power_status,
              low_power_access_failure, data_valid_failure};
          end
          op_breakpoint_read_command: rsp.data <= breakpoint_match_address;
          op_read_byte: begin
            if (force_hit) begin
              rsp.data <= {8'h00, FORCE_RESET_READ};
            end
          end
          default: rsp.data <= RSP_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_lp_status_set: assert property (@(posedge clk) disable iff (!reset_n)
    cpu.low_power |=> low_power_status)
    else $error("low-power status not set");
  a_refuse_in_lp: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd.valid && cpu.low_power && cmd.op != op_background) |=> rsp.valid && rsp.refused)
    else $error("command not refused in low power");
  a_bg_allowed: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd.valid && cmd.op == op_background && enable_debug)
    |=> background_req && !rsp.refused ##1 !background_req || $past(cmd.valid))
    else $error("background command not forwarded");
  a_fail_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_refused && is_mem_op) |=> low_power_access_failure)
    else $error("access failure flag not set");
  a_valid_fail_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd.valid && !cpu.low_power && cmd.op == op_read_status)
    |=> !rsp.data[STAT_DATA_VALID_FAIL])
    else $error("data-valid failure reported");
  a_bkpt_load: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_breakpoint_write_command) |=> breakpoint_match_address == $past(cmd.data))
    else $error("breakpoint address not loaded");
  a_bkpt_isolated: assert property (@(posedge clk) disable iff (!reset_n)
    !(cmd_ok && cmd.op == op_breakpoint_write_command) |=> $stable(breakpoint_match_address))
    else $error("breakpoint changed without command");
  a_ctrl_bits: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_write_control)
    |=> breakpoint_enable == $past(cmd.data[STAT_BKPT_EN])
    && force_tag_select == $past(cmd.data[STAT_FORCE_TAG]))
    else $error("control bits not written");
  a_user_no_reset: assert property (@(posedge clk) disable iff (!reset_n)
    (user_wr.valid && user_wr.addr == FORCE_ADDR && !cmd.valid) |=> !system_reset_req)
    else $error("user write caused reset");
  a_force_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_read_byte && force_hit) |=> rsp.data == 16'h0000)
    else $error("force-reset register read not zero");
  a_force_reset: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_write_byte && force_hit && cmd.data[FORCE_RESET_BIT])
    |=> system_reset_req ##1 !system_reset_req || $past(cmd.valid))
    else $error("forced reset not issued");
  a_active_flag: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_read_status)
    |=> rsp.data[STAT_ACTIVE] == $past(cpu.debug_active))
    else $error("debug-active flag wrong");
  a_status_ro: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_write_control && !low_power_access_failure
    && !cpu.wait_conflict) |=> !low_power_access_failure)
    else $error("status bit written by control write");

  // Flags, gating and response checks
  a_lp_status_wake: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd.valid && cmd.op == op_background && cpu.low_power && enable_debug)
    |=> low_power_status)
    else $error("low-power status not set on wake");
  a_lp_status_held: assert property (@(posedge clk) disable iff (!reset_n)
    (wake_state == st_wake_active && cpu.debug_active)
    |=> low_power_status)
    else $error("low-power status lost in debug mode");
  a_refused_no_data: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_refused
    |=> rsp.data == RSP_IDLE)
    else $error("refused command returned data");
  a_refused_ctrl_kept: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_refused && cmd.op == op_write_control)
    |=> $stable(breakpoint_enable) && $stable(force_tag_select))
    else $error("control bits written in low power");
  a_rsp_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !cmd.valid
    |=> !rsp.valid && !rsp.refused)
    else $error("response without command");
  a_bg_needs_enable: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd.valid && cmd.op == op_background && !enable_debug)
    |=> !background_req)
    else $error("background request while debug disabled");
  a_fail_on_conflict: assert property (@(posedge clk) disable iff (!reset_n)
    cpu.wait_conflict
    |=> low_power_access_failure)
    else $error("access failure flag missed a conflict");
  a_fail_cleared: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && is_mem_op && !cpu.wait_conflict)
    |=> !low_power_access_failure)
    else $error("access failure flag not cleared");
  a_bkpt_readback: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_breakpoint_read_command)
    |=> rsp.data == $past(breakpoint_match_address))
    else $error("breakpoint read returned wrong value");
  a_reset_source: assert property (@(posedge clk) disable iff (!reset_n)
    !(cmd_ok && cmd.op == op_write_byte && force_hit)
    |=> !system_reset_req)
    else $error("reset request without debug write");
  a_force_bit_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_write_byte && force_hit && !cmd.data[FORCE_RESET_BIT])
    |=> !system_reset_req)
    else $error("reset request with force bit clear");
  a_status_ro_lp: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_ok && cmd.op == op_write_control && !cpu.low_power && wake_state == st_idle)
    |=> !low_power_status)
    else $error("low-power status set by control write");

  c_wake: cover property (@(posedge clk) disable iff (!reset_n)
    wake_state == st_wake_req ##[1:20] wake_state == st_wake_active);
  c_force_reset: cover property (@(posedge clk) disable iff (!reset_n) system_reset_req);
  c_bkpt_write: cover property (@(posedge clk) disable iff (!reset_n)
    cmd_ok && cmd.op == op_breakpoint_write_command);
  c_refused: cover property (@(posedge clk) disable iff (!reset_n) rsp.refused);
  c_access_fail: cover property (@(posedge clk) disable iff (!reset_n)
    cmd_refused && is_mem_op);
endmodule : bdsr_core
`default_nettype wire

//--- dv/bdsr_host.sv
/*
  Model of the external debug host: issues one decoded command at a time.
  Assumes the caller stands just after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bdsr_host (
  // Clock
  input wire logic clk,
  // Command link
  output bdsr_pkg::bdsr_cmd_type cmd,
  input wire bdsr_pkg::bdsr_rsp_type rsp
);
  import bdsr_pkg::*;
  initial cmd = '0;
  ////////////////////////////////////////////////////////////////////////////
  // One command pulse; the answer is taken one edge later, then a gap cycle
  task automatic send(input bdsr_op_type op, input logic [15:0] addr,
                      input logic [15:0] data, output bdsr_rsp_type r);
    cmd <= '{valid: 1'b1, op: op, addr: addr, data: data};
    @(posedge clk);
    #1;
    r = rsp;
    // Released addr and data do not keep the last value; op does
    cmd <= '{valid: 1'b0, op: op, addr: ~addr, data: ~data};
    @(posedge clk);
    #1;
  endtask : send
endmodule : bdsr_host
`default_nettype wire

//--- dv/tb.sv
/*
  Self-checking bench for the debug status, breakpoint and forced-reset block.
  Assumes bdsr_core and the host model; CPU levels are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bdsr_pkg::*;
  typedef struct packed {
    bdsr_op_type op;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] exp;
  } bdsr_row_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  bdsr_cmd_type cmd;
  bdsr_rsp_type rsp;
  bdsr_rsp_type got;
  bdsr_cpu_type cpu = '0;
  bdsr_user_wr_type user_wr = '0;
  logic background_req;
  logic system_reset_req;
  logic breakpoint_enable;
  logic force_tag_select;
  logic [15:0] breakpoint_match_address;
  int num_errors = 0;
  int total_checks = 0;
  int bg_cnt = 0;
  int rst_cnt = 0;
  bdsr_row_type rows [6] = '{
    '{op_write_control, 16'h0000, 16'h00ff, 16'h0000},
    '{op_read_status, 16'h0000, 16'h0000, 16'h00b8},
    '{op_breakpoint_write_command, 16'h0000, 16'ha55a, 16'h0000},
    '{op_breakpoint_read_command, 16'h0000, 16'h0000, 16'ha55a},
    '{op_write_byte, FORCE_RESET_ADDR, 16'h00fe, 16'h0000},
    '{op_read_byte, FORCE_RESET_ADDR, 16'h0000, 16'h0000}};

  bdsr_core dut (.clk(clk), .reset_n(reset_n), .cmd(cmd), .rsp(rsp), .cpu(cpu),
    .user_wr(user_wr), .background_req(background_req),
    .system_reset_req(system_reset_req), .breakpoint_enable(breakpoint_enable),
    .force_tag_select(force_tag_select),
    .breakpoint_match_address(breakpoint_match_address));
  bdsr_host host (.clk(clk), .cmd(cmd), .rsp(rsp));

  always #4 clk = ~clk;
  // Pulse counters so one-cycle requests are never missed
  always @(posedge clk) begin
    if (background_req === 1'b1) bg_cnt <= bg_cnt + 1;
    if (system_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic chk_rsp(input logic refused, input logic [15:0] exp);
    chk("rsp_refused", {15'h0000, refused}, {15'h0000, got.refused});
    chk("rsp_data", exp, got.data);
    chk("rsp_valid", 16'h0001, {15'h0000, got.valid});
  endtask : chk_rsp
  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("rsp_valid", 16'h0000, {15'h0000, rsp.valid});
    chk("bkpt_en", 16'h0000, {15'h0000, breakpoint_enable});
    chk("reset_req", 16'h0000, {15'h0000, system_reset_req});
    chk("bkpt", 16'h0000, breakpoint_match_address);
    foreach (rows[i]) begin
      host.send(rows[i].op, rows[i].addr, rows[i].data, got);
      chk_rsp(1'b0, rows[i].exp);
    end
    chk("bkpt_en", 16'h0001, {15'h0000, breakpoint_enable});
    chk("force_tag_select", 16'h0001, {15'h0000, force_tag_select});
    chk("bkpt", 16'ha55a, breakpoint_match_address);
    chk("rst_cnt", 16'h0000, 16'(rst_cnt));
    cpu.low_power = 1'b1;
    host.send(op_read_status, 16'h0000, 16'h0000, got);
    chk_rsp(1'b1, 16'h0000);
    host.send(op_write_byte, 16'h0040, 16'h0001, got);
    chk_rsp(1'b1, 16'h0000);
    host.send(op_background, 16'h0000, 16'h0000, got);
    chk("bg_cnt", 16'h0001, 16'(bg_cnt));
    cpu = '{low_power: 1'b0, debug_active: 1'b1, wait_conflict: 1'b0};
    host.send(op_read_status, 16'h0000, 16'h0000, got);
    chk_rsp(1'b0, 16'h00fe);
    host.send(op_write_byte, 16'h0040, 16'h0001, got);
    host.send(op_write_control, 16'h0000, 16'h0000, got);
    host.send(op_read_status, 16'h0000, 16'h0000, got);
    chk_rsp(1'b0, 16'h00c4);
    chk("bkpt_en", 16'h0000, {15'h0000, breakpoint_enable});
    cpu.wait_conflict = 1'b1;
    @(posedge clk);
    #1;
    cpu.wait_conflict = 1'b0;
    host.send(op_read_status, 16'h0000, 16'h0000, got);
    chk_rsp(1'b0, 16'h00c6);
    user_wr = '{valid: 1'b1, addr: FORCE_RESET_ADDR, data: 8'h01};
    @(posedge clk);
    #1;
    user_wr = '0;
    host.send(op_read_status, 16'h0000, 16'h0000, got);
    chk("rst_cnt", 16'h0000, 16'(rst_cnt));
    host.send(op_write_byte, FORCE_RESET_ADDR, 16'h0001, got);
    chk("rst_cnt", 16'h0001, 16'(rst_cnt));
    cpu = '0;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("bkpt", 16'h0000, breakpoint_match_address);
    host.send(op_read_status, 16'h0000, 16'h0000, got);
    chk_rsp(1'b0, 16'h0000);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
